// [rtl/adcctl_defs.vh]
// Constants for the converter control register block.
`ifndef ADCCTL_DEFS_VH
`define ADCCTL_DEFS_VH
`define ADCCTL_OFF_RESULT_LOW     12'h000
`define ADCCTL_OFF_RESULT_HIGH    12'h004
`define ADCCTL_OFF_CONV_CTRL      12'h008
`define ADCCTL_OFF_SRC_CLK_SEL    12'h00C
`define ADCCTL_OFF_REF_SEL        12'h010
`define ADCCTL_OFF_STATUS         12'h014
`define ADCCTL_CTRL_RESET         8'h00
`define ADCCTL_BIT_START          7
`define ADCCTL_BIT_BUSY           6
`define ADCCTL_BIT_ENABLE         5
`define ADCCTL_BIT_ALIGN          4
`define ADCCTL_CTRL_WMASK         8'hB7
`define ADCCTL_SRC_WMASK          8'hE7
`define ADCCTL_REF_WMASK          8'hCF
`define ADCCTL_BIT_AMP_EN         7
`define ADCCTL_BIT_BG_EN          6
`define ADCCTL_SAMPLE_CYCLES      5'd4
`define ADCCTL_CONVERT_CYCLES     5'd12
`define ADCCTL_TOTAL_CYCLES       5'd16
`define ADCCTL_SRC_EXT            3'h0
`define ADCCTL_SRC_RSV            3'h4
`define ADCCTL_REF_SUPPLY         4'h0
`define ADCCTL_REF_INHIBIT        4'h9
`endif

// [rtl/adcctl_top.v]
// APB register block and sequencer for an eight channel 12-bit converter.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "adcctl_defs.vh"
module adcctl_top #(
  parameter DATA_W = 12
) (
  input  wire              REF_CLK,
  input  wire              NRST,
  input  wire              PSEL,
  input  wire              PENABLE,
  input  wire              PWRITE,
  input  wire [11:0]       PADDR,
  input  wire [31:0]       PWDATA,
  output reg  [31:0]       PRDATA,
  output reg               PREADY,
  output reg               PSLVERR,
  input  wire [DATA_W-1:0] CONV_DATA,
  output reg               CONV_POWER,
  output reg               CONV_SAMPLE,
  output reg               CONV_CLK_EN,
  output reg               CONV_DONE,
  output reg  [2:0]        CHANNEL_SEL,
  output reg               CHANNEL_CONNECT,
  output reg  [2:0]        INTERNAL_SEL,
  output reg  [3:0]        REF_SEL,
  output reg               REF_AMP_BANDGAP,
  output reg               REF_AMP_ENABLE,
  output reg               BANDGAP_BUF_ENABLE
);

////////////////////////////////////////////////////////////////////////////////
// Reset release and register state.
reg        rst_s1_r;
reg        rst_n_r;
reg  [7:0] conv_ctrl_r;
reg  [7:0] src_clk_r;
reg  [7:0] ref_sel_r;
reg  [7:0] res_low_r;
reg  [7:0] res_high_r;
reg        busy_r;
reg        done_flag_r;
reg  [6:0] div_cnt_r;
reg  [4:0] cyc_cnt_r;
wire       acc_w;
wire       acc_r;
wire       wr_ctrl;
wire       start_rise;
wire       start_fall;
wire       conv_tick;
wire [6:0] div_last;
wire [2:0] src_eff;
wire [3:0] ref_eff;
wire [11:0] res_val;
reg  [7:0] rd_nxt;
reg        err_nxt;

always @(posedge REF_CLK or negedge NRST) begin
  if (!NRST) begin
    rst_s1_r <= 1'b0;
    rst_n_r  <= 1'b0;
  end else begin
    rst_s1_r <= 1'b1;
    rst_n_r  <= rst_s1_r;
  end
end

// Every access completes in its first access cycle, so no wait state is needed.
assign acc_w      = PSEL & PENABLE & PWRITE;
assign acc_r      = PSEL & PENABLE & ~PWRITE;
assign wr_ctrl    = acc_w && (PADDR == `ADCCTL_OFF_CONV_CTRL);
assign start_rise = wr_ctrl & ~conv_ctrl_r[`ADCCTL_BIT_START] & PWDATA[`ADCCTL_BIT_START];
assign start_fall = wr_ctrl & conv_ctrl_r[`ADCCTL_BIT_START] & ~PWDATA[`ADCCTL_BIT_START];

////////////////////////////////////////////////////////////////////////////////
// Control registers.
always @(posedge REF_CLK or negedge rst_n_r) begin
  if (!rst_n_r) begin
    conv_ctrl_r <= `ADCCTL_CTRL_RESET;
    src_clk_r   <= `ADCCTL_CTRL_RESET;
    ref_sel_r   <= `ADCCTL_CTRL_RESET;
  end else if (acc_w) begin
    case (PADDR)
      `ADCCTL_OFF_CONV_CTRL: begin
        conv_ctrl_r <= PWDATA[7:0] & `ADCCTL_CTRL_WMASK;
      end
      `ADCCTL_OFF_SRC_CLK_SEL: begin
        src_clk_r <= PWDATA[7:0] & `ADCCTL_SRC_WMASK;
      end
      `ADCCTL_OFF_REF_SEL: begin
        ref_sel_r <= PWDATA[7:0] & `ADCCTL_REF_WMASK;
      end
      default: begin
        conv_ctrl_r <= conv_ctrl_r;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Conversion clock divider and sequencer.
assign div_last  = (7'h01 << src_clk_r[2:0]) - 7'h01;
assign conv_tick = (div_cnt_r == div_last);

always @(posedge REF_CLK or negedge rst_n_r) begin
  if (!rst_n_r) begin
    div_cnt_r   <= 7'h00;
    cyc_cnt_r   <= 5'h00;
    busy_r      <= 1'b0;
    done_flag_r <= 1'b0;
    res_low_r   <= 8'h00;
    res_high_r  <= 8'h00;
  end else begin
    if (start_rise || !conv_ctrl_r[`ADCCTL_BIT_ENABLE]) begin
      busy_r    <= 1'b0;
      div_cnt_r <= 7'h00;
      cyc_cnt_r <= 5'h00;
    end else if (start_fall) begin
      busy_r      <= 1'b1;
      div_cnt_r   <= 7'h00;
      cyc_cnt_r   <= 5'h00;
      done_flag_r <= 1'b0;
    end else if (busy_r) begin
      div_cnt_r <= conv_tick ? 7'h00 : div_cnt_r + 7'h01;
      if (conv_tick) begin
        cyc_cnt_r <= cyc_cnt_r + 5'h01;
        if (cyc_cnt_r == `ADCCTL_TOTAL_CYCLES - 5'd1) begin
          busy_r      <= 1'b0;
          done_flag_r <= 1'b1;
          if (conv_ctrl_r[`ADCCTL_BIT_ALIGN]) begin
            res_high_r <= {4'h0, res_val[11:8]};
            res_low_r  <= res_val[7:0];
          end else begin
            res_high_r <= res_val[11:4];
            res_low_r  <= {res_val[3:0], 4'h0};
          end
        end
      end
    end
    // Reading the status word acknowledges the completion flag; a new completion wins.
    if (acc_r && PADDR == `ADCCTL_OFF_STATUS && !(busy_r && conv_tick &&
        cyc_cnt_r == `ADCCTL_TOTAL_CYCLES - 5'd1)) begin
      done_flag_r <= 1'b0;
    end
  end
end
// Result registers are untouched by disabling, so the last value survives.
assign res_val = CONV_DATA[11:0];

////////////////////////////////////////////////////////////////////////////////
// Source and reference selection.
assign src_eff = (src_clk_r[7:5] == `ADCCTL_SRC_RSV) ? `ADCCTL_SRC_EXT : src_clk_r[7:5];
assign ref_eff = (ref_sel_r[3:0] <= 4'h4 || (ref_sel_r[3:0] >= 4'hA && ref_sel_r[3:0] <= 4'hC)) ?
                 ref_sel_r[3:0] : `ADCCTL_REF_SUPPLY;

always @(posedge REF_CLK or negedge rst_n_r) begin
  if (!rst_n_r) begin
    CONV_POWER         <= 1'b0;
    CONV_SAMPLE        <= 1'b0;
    CONV_CLK_EN        <= 1'b0;
    CONV_DONE          <= 1'b0;
    CHANNEL_SEL        <= 3'h0;
    CHANNEL_CONNECT    <= 1'b0;
    INTERNAL_SEL       <= 3'h0;
    REF_SEL            <= 4'h0;
    REF_AMP_BANDGAP    <= 1'b0;
    REF_AMP_ENABLE     <= 1'b0;
    BANDGAP_BUF_ENABLE <= 1'b0;
  end else begin
    CONV_POWER         <= conv_ctrl_r[`ADCCTL_BIT_ENABLE];
    CONV_SAMPLE        <= busy_r && (cyc_cnt_r < `ADCCTL_SAMPLE_CYCLES);
    CONV_CLK_EN        <= busy_r & conv_tick;
    CONV_DONE          <= done_flag_r;
    CHANNEL_SEL        <= conv_ctrl_r[2:0];
    CHANNEL_CONNECT    <= (src_eff == `ADCCTL_SRC_EXT);
    INTERNAL_SEL       <= src_eff;
    REF_SEL            <= ref_eff;
    REF_AMP_BANDGAP    <= ref_eff[3];
    REF_AMP_ENABLE     <= ref_sel_r[`ADCCTL_BIT_AMP_EN];
    BANDGAP_BUF_ENABLE <= ref_sel_r[`ADCCTL_BIT_BG_EN];
  end
end

////////////////////////////////////////////////////////////////////////////////
// APB read path.
always @* begin
  rd_nxt  = 8'h00;
  err_nxt = 1'b0;
  case (PADDR)
    `ADCCTL_OFF_RESULT_LOW:  rd_nxt = res_low_r;
    `ADCCTL_OFF_RESULT_HIGH: rd_nxt = res_high_r;
    `ADCCTL_OFF_CONV_CTRL: begin
      rd_nxt = conv_ctrl_r;
      rd_nxt[`ADCCTL_BIT_BUSY] = busy_r;
    end
    `ADCCTL_OFF_SRC_CLK_SEL: rd_nxt = src_clk_r;
    `ADCCTL_OFF_REF_SEL:     rd_nxt = ref_sel_r;
    `ADCCTL_OFF_STATUS:      rd_nxt = {7'h00, done_flag_r};
    default:                 err_nxt = 1'b1;
  endcase
end

// Read data is registered in setup so it is stable for the whole access phase.
always @(posedge REF_CLK or negedge rst_n_r) begin
  if (!rst_n_r) begin
    PRDATA  <= 32'h0000_0000;
    PREADY  <= 1'b0;
    PSLVERR <= 1'b0;
  end else begin
    PREADY  <= PSEL & ~PENABLE;
    PSLVERR <= PSEL & ~PENABLE & err_nxt;
    if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= {24'h00_0000, rd_nxt};
    end
  end
end

endmodule

// [sim/adcctl_properties.sv]
// Port-level assertions for the converter control block.
`timescale 1ns/1ps
module adcctl_properties (
  input logic        REF_CLK,
  input logic        NRST,
  input logic        PSEL,
  input logic        PENABLE,
  input logic        PWRITE,
  input logic [11:0] PADDR,
  input logic [31:0] PWDATA,
  input logic        CONV_POWER,
  input logic        CONV_SAMPLE,
  input logic        CONV_CLK_EN,
  input logic [2:0]  CHANNEL_SEL,
  input logic        CHANNEL_CONNECT,
  input logic [2:0]  INTERNAL_SEL,
  input logic [3:0]  REF_SEL,
  input logic        REF_AMP_BANDGAP,
  input logic        REF_AMP_ENABLE,
  input logic        BANDGAP_BUF_ENABLE
);
  logic [2:0] live_cnt;
  logic [2:0] tick_cnt;
  // The block leaves reset two edges after the pin and its outputs one edge later.
  always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      live_cnt <= 3'd0;
    end else if (live_cnt != 3'd4) begin
      live_cnt <= live_cnt + 3'd1;
    end
  end
  // Counts conversion clock ticks while the sampling phase is shown.
  always @(posedge REF_CLK) begin
    if (!CONV_SAMPLE) begin
      tick_cnt <= 3'd0;
    end else if (CONV_CLK_EN) begin
      tick_cnt <= tick_cnt + 3'd1;
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST || live_cnt != 3'd4);
  // A write lands at the access edge and its pin follows one clock later.
  sequence wr(a);
    PSEL && PENABLE && PWRITE && PADDR == a;
  endsequence
  a_power_bit: assert property (wr(12'h008) |-> ##2 CONV_POWER == $past(PWDATA[5], 2))
    else $error("power pin wrong");
  a_channel_field: assert property (wr(12'h008) |-> ##2 CHANNEL_SEL == $past(PWDATA[2:0], 2))
    else $error("channel pin wrong");
  a_amp_enable: assert property (wr(12'h010) |-> ##2 REF_AMP_ENABLE == $past(PWDATA[7], 2))
    else $error("amplifier enable wrong");
  a_bandgap_buf: assert property (wr(12'h010) |-> ##2 BANDGAP_BUF_ENABLE == $past(PWDATA[6], 2))
    else $error("bandgap buffer wrong");
  a_ext_connect: assert property (CHANNEL_CONNECT == (INTERNAL_SEL == 3'h0))
    else $error("external connect wrong");
  a_src_folded: assert property (INTERNAL_SEL != 3'h4)
    else $error("reserved source seen");
  a_ref_legal: assert property (REF_SEL inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hA, 4'hB, 4'hC})
    else $error("illegal reference code");
  a_ref_bandgap: assert property (REF_AMP_BANDGAP == REF_SEL[3])
    else $error("bandgap switch wrong");
  a_sample_len: assert property (CONV_SAMPLE && CONV_CLK_EN && tick_cnt == 3'd3 |=> !CONV_SAMPLE)
    else $error("sampling phase length wrong");
endmodule
bind adcctl_top adcctl_properties u_props (.*);

// [sim/adcctl_src_model.sv]
// Behavioural model of the analog sources feeding the converter.
`timescale 1ns/1ps
module adcctl_src_model (
  input  logic        clk,
  input  logic        power,
  input  logic [2:0]  chan,
  input  logic        conn,
  input  logic [2:0]  isel,
  output logic [11:0] data
);
  initial data = 12'h000;
  // An unpowered core gives no stable code, so the value churns every cycle.
  always @(posedge clk) begin
    if (!power) data <= ~data;
    else if (conn) data <= {9'h1A5, chan};
    else data <= {9'h0C3, isel};
  end
endmodule

// [sim/test_adc_control_registers.sv]
// Register-level tests of the converter control block.
`timescale 1ns/1ps
`include "adcctl_defs.vh"
module test_adc_control_registers;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, pwr, conn, done;
  logic [2:0]  chan, isel;
  logic [11:0] cdata, ev;
  logic [7:0]  cb;
  int          fail_count = 0;
  int          checks = 0;
  always #4 clk = ~clk;
  adcctl_top dut (.REF_CLK(clk), .NRST(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CONV_DATA(cdata), .CONV_POWER(pwr), .CONV_SAMPLE(), .CONV_CLK_EN(), .CONV_DONE(done),
    .CHANNEL_SEL(chan), .CHANNEL_CONNECT(conn), .INTERNAL_SEL(isel), .REF_SEL(),
    .REF_AMP_BANDGAP(), .REF_AMP_ENABLE(), .BANDGAP_BUF_ENABLE());
  adcctl_src_model src (.clk(clk), .power(pwr), .chan(chan), .conn(conn), .isel(isel), .data(cdata));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdchk(input logic [11:0] a, input logic [7:0] e);
    xfer(0, a, 8'h00);
    chk(rd, {24'h00_0000, e});
  endtask
  task wrap_up;
    $display("checks=%0d mismatches=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rdchk(`ADCCTL_OFF_CONV_CTRL, 8'h00);
    rdchk(`ADCCTL_OFF_RESULT_HIGH, 8'h00);
    xfer(1, `ADCCTL_OFF_CONV_CTRL, 8'hFF);
    rdchk(`ADCCTL_OFF_CONV_CTRL, 8'hB7);
    xfer(1, `ADCCTL_OFF_SRC_CLK_SEL, 8'hFF);
    rdchk(`ADCCTL_OFF_SRC_CLK_SEL, 8'hE7);
    xfer(1, `ADCCTL_OFF_REF_SEL, 8'h80);
    for (int r = 0; r < 16; r++) if (r != 9) begin
      xfer(1, `ADCCTL_OFF_REF_SEL, {4'hC, r[3:0]});
      rdchk(`ADCCTL_OFF_REF_SEL, {4'hC, r[3:0]});
    end
    xfer(0, 12'h020, 8'h00);
    chk(32'(err), 1);
    chk(rd, 0);
    $display("test registers done");
    // Every source code, every channel, both alignments and four divider codes.
    for (int s = 0; s < 8; s++) begin
      cb = {3'b000, s[0], 1'b0, 3'(7 - s)};
      ev = (s == 0 || s == 4) ? {9'h1A5, 3'(7 - s)} : {9'h0C3, 3'(s)};
      xfer(1, `ADCCTL_OFF_SRC_CLK_SEL, {s[2:0], 3'b000, s[1:0]});
      xfer(1, `ADCCTL_OFF_CONV_CTRL, 8'hA0 | cb);
      rdchk(`ADCCTL_OFF_CONV_CTRL, 8'hA0 | cb);
      xfer(1, `ADCCTL_OFF_CONV_CTRL, 8'h20 | cb);
      rdchk(`ADCCTL_OFF_CONV_CTRL, 8'h60 | cb);
      repeat ((16 << s[1:0]) - 5) @(posedge clk);
      rdchk(`ADCCTL_OFF_CONV_CTRL, 8'h60 | cb);
      rdchk(`ADCCTL_OFF_CONV_CTRL, 8'h20 | cb);
      rdchk(`ADCCTL_OFF_RESULT_HIGH, s[0] ? {4'h0, ev[11:8]} : ev[11:4]);
      rdchk(`ADCCTL_OFF_RESULT_LOW, s[0] ? ev[7:0] : {ev[3:0], 4'h0});
      chk(32'(done), 32'h0000_0001);
      rdchk(`ADCCTL_OFF_STATUS, 8'h01);
    end
    xfer(1, `ADCCTL_OFF_CONV_CTRL, 8'hB1);
    xfer(1, `ADCCTL_OFF_CONV_CTRL, 8'h31);
    xfer(1, `ADCCTL_OFF_CONV_CTRL, 8'hB1);
    rdchk(`ADCCTL_OFF_CONV_CTRL, 8'hB1);
    xfer(1, `ADCCTL_OFF_CONV_CTRL, 8'h80);
    repeat (200) @(posedge clk);
    rdchk(`ADCCTL_OFF_RESULT_LOW, ev[7:0]);
    $display("test conversions done");
    wrap_up;
  end
endmodule
